// >>> rtl/sca_pkg.sv
/*
  Package of the statistics counter access port: register indices, field
  positions, reset values, operation codes, selection codes and carriers.
  Assumes a 32-bit AHB-Lite bus; each register takes one aligned word at
  four times its index.
*/
// Functional notes
// - Register 0x215 reads byte 2 of the selected counter after a read-out and holds the byte 2 value to load.
// - Register 0x216 reads byte 1, the least significant byte, and holds the byte 1 value to load.
// - Staged bytes meet the counter only when a transfer command is issued, never on the register write.
// - Category bits 7:4 codes 1011, 1010, 1001, 1000 pick the input all, idle, unassigned and HEC error counters.
// - Category codes 0111, 0110, 0101, 0100 pick transmit total, idle or filler, stuff and ICP counters.
// - Category codes 0011, 0010, 0001, 0000 pick receive total, idle or filler, HEC error and bad ICP counters.
// - Instance bits 3:0 give groups 0 to 3 as 1000 to 1011 for input counters and links 0 to 3 as 0000 to 0011.
// - Command bit 7 reads 1 when the transfer is done and 0 while pending; software writes it as 0.
// - Command bit 2 at 0 loads the counter from the staging bytes and at 1 copies the counter out to them.
// - Operation 01 moves the counter value, 10 moves the interrupt enable bit, 00 and 11 are never issued.
// - Command bit 3 is the interrupt enable value and moves only with operation 10.
// - Staging, selection and command registers all reset to 00, reserved command bits 6:4 included.
// - Register 0x214 reads byte 3, the most significant byte, and holds the byte 3 value to load.
package sca_pkg;

  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [9:0] SCA_IDX_BYTE3  = 10'h214;
  localparam logic [9:0] SCA_IDX_BYTE2  = 10'h215;
  localparam logic [9:0] SCA_IDX_BYTE1  = 10'h216;
  localparam logic [9:0] SCA_IDX_SELECT = 10'h217;
  localparam logic [9:0] SCA_IDX_CMD    = 10'h21a;
  localparam logic [9:0] SCA_IDX_IRQ_ST = 10'h21b;
  localparam logic [9:0] SCA_IDX_IRQ_MK = 10'h21c;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] SCA_RST_BYTE   = 8'h00;
  localparam logic [7:0] SCA_RST_SELECT = 8'h00;
  localparam logic [7:0] SCA_RST_CMD    = 8'h00;
  localparam logic [1:0] SCA_RST_IRQ    = 2'h0;

  // ---------------------------------------------------------------
  // Command fields
  // ---------------------------------------------------------------
  localparam int SCA_CMD_DONE_BIT = 7;
  localparam int SCA_CMD_RSV_LSB  = 4;
  localparam int SCA_CMD_IEN_BIT  = 3;
  localparam int SCA_CMD_DIR_BIT  = 2;
  localparam int SCA_CMD_OP_LSB   = 0;
  localparam logic [1:0] SCA_OP_VALUE = 2'h1;
  localparam logic [1:0] SCA_OP_IEN   = 2'h2;
  localparam logic       SCA_DIR_OUT  = 1'h1;

  // ---------------------------------------------------------------
  // Interrupt status bits
  // ---------------------------------------------------------------
  localparam int SCA_IRQ_DONE_BIT = 0;
  localparam int SCA_IRQ_ERR_BIT  = 1;

  // ---------------------------------------------------------------
  // Selection codes
  // ---------------------------------------------------------------
  localparam logic [1:0] SCA_SEL_UTO_HI  = 2'h2;
  localparam logic [1:0] SCA_SEL_TX_HI   = 2'h1;
  localparam logic [1:0] SCA_SEL_RX_HI   = 2'h0;
  localparam logic [1:0] SCA_INST_UTO_HI = 2'h2;
  localparam logic [1:0] SCA_INST_LNK_HI = 2'h0;

  // Counter families
  typedef enum logic [1:0] {
    SCA_KIND_RX  = 2'h0,
    SCA_KIND_TX  = 2'h1,
    SCA_KIND_UTO = 2'h2
  } sca_kind_type;

  // Request towards the counter bank
  typedef struct packed {
    logic         valid;
    logic [1:0]   op;
    logic         dir;
    sca_kind_type kind;
    logic [1:0]   ctr;
    logic [1:0]   unit;
    logic [23:0]  wdata;
    logic         ien;
  } sca_ctr_req_type;

  // Answer from the counter bank
  typedef struct packed {
    logic        ack;
    logic [23:0] rdata;
    logic        ien;
  } sca_ctr_rsp_type;

endpackage

// >>> rtl/sca_sel_decode.sv
/*
  Decoder of the counter selection register into counter family, counter
  within the family and link or group number.
  Assumes the selection value is a stable register output.
*/
`timescale 1ns/100ps
`default_nettype none
module sca_sel_decode
  import sca_pkg::*;
(
  // Selection
  input  wire logic [7:0]   i_sel,
  // Decoded counter
  output var  logic         o_valid,
  output var  sca_kind_type o_kind,
  output var  logic [1:0]   o_ctr,
  output var  logic [1:0]   o_unit
);

  // ---------------------------------------------------------------
  // Category and instance decode
  // ---------------------------------------------------------------
  always_comb begin
    o_ctr  = i_sel[5:4];
    o_unit = i_sel[1:0];
    o_kind = SCA_KIND_RX;
    o_valid = 1'b0;
    if (i_sel[7:6] == SCA_SEL_UTO_HI) begin
      o_kind  = SCA_KIND_UTO;
      o_valid = (i_sel[3:2] == SCA_INST_UTO_HI);
    end else if (i_sel[7:6] == SCA_SEL_TX_HI) begin
      o_kind  = SCA_KIND_TX;
      o_valid = (i_sel[3:2] == SCA_INST_LNK_HI);
    end else if (i_sel[7:6] == SCA_SEL_RX_HI) begin
      o_kind  = SCA_KIND_RX;
      o_valid = (i_sel[3:2] == SCA_INST_LNK_HI);
    end
  end

endmodule
`default_nettype wire

// >>> rtl/sca_access_port.sv
/*
  Indirect access port to the cell statistics counters: staging bytes,
  selection, transfer command with done flag, interrupt status and mask,
  all reached over an AHB-Lite slave.
  Assumes a counter bank that holds a request until it answers with a
  one-cycle acknowledge.
*/
// Chosen here: register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
module sca_access_port
  import sca_pkg::*;
(
  // Clock and reset
  input  wire logic            i_clk,
  input  wire logic            i_reset_n,
  // AHB-Lite slave
  input  wire logic            i_hsel,
  input  wire logic [31:0]     i_haddr,
  input  wire logic [1:0]      i_htrans,
  input  wire logic            i_hwrite,
  input  wire logic [2:0]      i_hsize,
  input  wire logic [31:0]     i_hwdata,
  input  wire logic            i_hready,
  output var  logic [31:0]     o_hrdata,
  output var  logic            o_hreadyout,
  output var  logic            o_hresp,
  // Counter bank
  output var  sca_ctr_req_type o_ctr_req,
  input  wire sca_ctr_rsp_type i_ctr_rsp,
  // Interrupt
  output var  logic            o_irq
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SCA_ST_IDLE = 2'b01,
    SCA_ST_WAIT = 2'b10
  } sca_state_type;

  sca_state_type   state_reg;
  sca_ctr_req_type req_reg;
  logic [7:0]      byte3_reg;
  logic [7:0]      byte2_reg;
  logic [7:0]      byte1_reg;
  logic [7:0]      select_reg;
  logic            done_reg;
  logic [2:0]      cmd_rsv_reg;
  logic            cmd_ien_reg;
  logic            cmd_dir_reg;
  logic [1:0]      cmd_op_reg;
  logic [1:0]      irq_st_reg;
  logic [1:0]      irq_st_next;
  logic [1:0]      irq_mk_reg;
  logic            irq_reg;
  logic            wr_pend_reg;
  logic [9:0]      wr_idx_reg;
  logic            rd_pend_reg;
  logic [9:0]      rd_idx_reg;
  logic [31:0]     hrdata_reg;
  logic            hready_reg;
  logic            accept;
  logic            wr_b3;
  logic            wr_b2;
  logic            wr_b1;
  logic            wr_sel;
  logic            wr_cmd;
  logic            wr_st;
  logic            wr_mk;
  logic [1:0]      wr_op;
  logic            op_legal;
  logic            start;
  logic            ack_done;
  logic            capture;
  logic            ien_capture;
  logic            ev_err;
  logic            sel_valid;
  sca_kind_type    sel_kind;
  logic [1:0]      sel_ctr;
  logic [1:0]      sel_unit;
  logic [7:0]      cmd_value;
  logic [31:0]     rd_mux;

  // Selection decode
  sca_sel_decode u_decode (
    .i_sel   (select_reg),
    .o_valid (sel_valid),
    .o_kind  (sel_kind),
    .o_ctr   (sel_ctr),
    .o_unit  (sel_unit)
  );

  // ---------------------------------------------------------------
  // AHB-Lite address and data phase
  // ---------------------------------------------------------------
  // Address phase taken when selected, NONSEQ or SEQ, and bus ready
  assign accept = i_hsel && i_htrans[1] && i_hready;

  // Write strobes in the data phase
  assign wr_b3  = wr_pend_reg && (wr_idx_reg == SCA_IDX_BYTE3);
  assign wr_b2  = wr_pend_reg && (wr_idx_reg == SCA_IDX_BYTE2);
  assign wr_b1  = wr_pend_reg && (wr_idx_reg == SCA_IDX_BYTE1);
  assign wr_sel = wr_pend_reg && (wr_idx_reg == SCA_IDX_SELECT);
  assign wr_cmd = wr_pend_reg && (wr_idx_reg == SCA_IDX_CMD);
  assign wr_st  = wr_pend_reg && (wr_idx_reg == SCA_IDX_IRQ_ST);
  assign wr_mk  = wr_pend_reg && (wr_idx_reg == SCA_IDX_IRQ_MK);

  // Bus phase tracking; reads take one wait state so writes settle first
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg  <= 10'h000;
      rd_pend_reg <= 1'b0;
      rd_idx_reg  <= 10'h000;
      hready_reg  <= 1'b1;
      hrdata_reg  <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= accept && i_hwrite;
      wr_idx_reg  <= i_haddr[11:2];
      if (accept && !i_hwrite) begin
        rd_pend_reg <= 1'b1;
        rd_idx_reg  <= i_haddr[11:2];
        hready_reg  <= 1'b0;
      end else if (rd_pend_reg) begin
        rd_pend_reg <= 1'b0;
        hrdata_reg  <= rd_mux;
        hready_reg  <= 1'b1;
      end
    end
  end

  // Read data select; unmapped words read zero
  assign cmd_value = {done_reg, cmd_rsv_reg, cmd_ien_reg, cmd_dir_reg,
                      cmd_op_reg};
  always_comb begin
    if (rd_idx_reg == SCA_IDX_BYTE3) begin
      rd_mux = {24'h00_0000, byte3_reg};
    end else if (rd_idx_reg == SCA_IDX_BYTE2) begin
      rd_mux = {24'h00_0000, byte2_reg};
    end else if (rd_idx_reg == SCA_IDX_BYTE1) begin
      rd_mux = {24'h00_0000, byte1_reg};
    end else if (rd_idx_reg == SCA_IDX_SELECT) begin
      rd_mux = {24'h00_0000, select_reg};
    end else if (rd_idx_reg == SCA_IDX_CMD) begin
      rd_mux = {24'h00_0000, cmd_value};
    end else if (rd_idx_reg == SCA_IDX_IRQ_ST) begin
      rd_mux = {30'h0000_0000, irq_st_reg};
    end else if (rd_idx_reg == SCA_IDX_IRQ_MK) begin
      rd_mux = {30'h0000_0000, irq_mk_reg};
    end else begin
      rd_mux = 32'h0000_0000;
    end
  end

  assign o_hrdata    = hrdata_reg;
  assign o_hreadyout = hready_reg;
  assign o_hresp     = 1'b0;

  // ---------------------------------------------------------------
  // Transfer control
  // ---------------------------------------------------------------
  assign wr_op    = i_hwdata[SCA_CMD_OP_LSB+1:SCA_CMD_OP_LSB];
  assign op_legal = (wr_op == SCA_OP_VALUE) || (wr_op == SCA_OP_IEN);
  assign start    = wr_cmd && (state_reg == SCA_ST_IDLE) && op_legal
                    && sel_valid;
  assign ev_err   = wr_cmd && (state_reg == SCA_ST_IDLE)
                    && !(op_legal && sel_valid);
  assign ack_done = (state_reg == SCA_ST_WAIT) && i_ctr_rsp.ack;
  assign capture  = ack_done && (req_reg.op == SCA_OP_VALUE)
                    && (req_reg.dir == SCA_DIR_OUT);
  assign ien_capture = ack_done && (req_reg.op == SCA_OP_IEN)
                       && (req_reg.dir == SCA_DIR_OUT);

  // Sequencer: one request held until the counter bank acknowledges
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      state_reg <= SCA_ST_IDLE;
      req_reg   <= '0;
      done_reg  <= SCA_RST_CMD[SCA_CMD_DONE_BIT];
    end else begin
      case (state_reg)
        SCA_ST_IDLE: begin
          if (start) begin
            state_reg     <= SCA_ST_WAIT;
            done_reg      <= 1'b0;
            req_reg.valid <= 1'b1;
            req_reg.op    <= wr_op;
            req_reg.dir   <= i_hwdata[SCA_CMD_DIR_BIT];
            req_reg.kind  <= sel_kind;
            req_reg.ctr   <= sel_ctr;
            req_reg.unit  <= sel_unit;
            req_reg.wdata <= {byte3_reg, byte2_reg, byte1_reg};
            req_reg.ien   <= i_hwdata[SCA_CMD_IEN_BIT];
          end
        end
        SCA_ST_WAIT: begin
          if (i_ctr_rsp.ack) begin
            state_reg     <= SCA_ST_IDLE;
            done_reg      <= 1'b1;
            req_reg.valid <= 1'b0;
          end
        end
        default: begin
          state_reg     <= SCA_ST_IDLE;
          req_reg.valid <= 1'b0;
        end
      endcase
    end
  end

  assign o_ctr_req = req_reg;

  // ---------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------
  // Staging bytes; a read-out snapshot wins over a host write
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      byte3_reg <= SCA_RST_BYTE;
      byte2_reg <= SCA_RST_BYTE;
      byte1_reg <= SCA_RST_BYTE;
    end else if (capture) begin
      byte3_reg <= i_ctr_rsp.rdata[23:16];
      byte2_reg <= i_ctr_rsp.rdata[15:8];
      byte1_reg <= i_ctr_rsp.rdata[7:0];
    end else begin
      if (wr_b3) begin
        byte3_reg <= i_hwdata[7:0];
      end
      if (wr_b2) begin
        byte2_reg <= i_hwdata[7:0];
      end
      if (wr_b1) begin
        byte1_reg <= i_hwdata[7:0];
      end
    end
  end

  // Selection register; frozen while a transfer is pending
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      select_reg <= SCA_RST_SELECT;
    end else if (wr_sel && (state_reg == SCA_ST_IDLE)) begin
      select_reg <= i_hwdata[7:0];
    end
  end

  // Command fields; a write while pending is ignored
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      cmd_rsv_reg <= SCA_RST_CMD[SCA_CMD_RSV_LSB+2:SCA_CMD_RSV_LSB];
      cmd_ien_reg <= SCA_RST_CMD[SCA_CMD_IEN_BIT];
      cmd_dir_reg <= SCA_RST_CMD[SCA_CMD_DIR_BIT];
      cmd_op_reg  <= SCA_RST_CMD[SCA_CMD_OP_LSB+1:SCA_CMD_OP_LSB];
    end else if (ien_capture) begin
      cmd_ien_reg <= i_ctr_rsp.ien;
    end else if (wr_cmd && (state_reg == SCA_ST_IDLE)) begin
      cmd_rsv_reg <= i_hwdata[SCA_CMD_RSV_LSB+2:SCA_CMD_RSV_LSB];
      cmd_ien_reg <= i_hwdata[SCA_CMD_IEN_BIT];
      cmd_dir_reg <= i_hwdata[SCA_CMD_DIR_BIT];
      cmd_op_reg  <= wr_op;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt status, mask and output
  // ---------------------------------------------------------------
  // Sticky events, write one to clear, a new event wins over the clear
  always_comb begin
    irq_st_next = irq_st_reg;
    if (wr_st) begin
      irq_st_next = irq_st_reg & ~i_hwdata[1:0];
    end
    if (ack_done) begin
      irq_st_next[SCA_IRQ_DONE_BIT] = 1'b1;
    end
    if (ev_err) begin
      irq_st_next[SCA_IRQ_ERR_BIT] = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      irq_st_reg <= SCA_RST_IRQ;
      irq_mk_reg <= SCA_RST_IRQ;
      irq_reg    <= 1'b0;
    end else begin
      irq_st_reg <= irq_st_next;
      if (wr_mk) begin
        irq_mk_reg <= i_hwdata[1:0];
      end
      irq_reg <= |(irq_st_reg & irq_mk_reg);
    end
  end

  assign o_irq = irq_reg;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  a_byte2_snapshot: assert property (
    capture |=> byte2_reg == $past(i_ctr_rsp.rdata[15:8]))
    else $error("byte 2 not captured");
  a_byte1_snapshot: assert property (
    capture |=> byte1_reg == $past(i_ctr_rsp.rdata[7:0]))
    else $error("byte 1 not captured");
  a_byte3_snapshot: assert property (
    capture |=> byte3_reg == $past(i_ctr_rsp.rdata[23:16]))
    else $error("byte 3 not captured");
  a_stage_loaded_on_start: assert property (
    start |=> o_ctr_req.wdata == $past({byte3_reg, byte2_reg, byte1_reg}))
    else $error("staged bytes not sent on command");
  a_stage_hold: assert property (
    !capture && !wr_b2 |=> $stable(byte2_reg))
    else $error("staging byte changed without cause");
  a_uto_code: assert property (
    start && select_reg[7:6] == SCA_SEL_UTO_HI |=> o_ctr_req.kind ==
    SCA_KIND_UTO && o_ctr_req.unit == $past(select_reg[1:0]))
    else $error("input counter selection wrong");
  a_link_inst: assert property (
    wr_cmd && state_reg == SCA_ST_IDLE && op_legal
    && select_reg[7:6] != SCA_SEL_UTO_HI && select_reg[3:2] != SCA_INST_LNK_HI
    |=> !o_ctr_req.valid)
    else $error("bad link instance started");
  a_done_pending: assert property (
    start |=> !done_reg throughout (state_reg == SCA_ST_WAIT)[*1])
    else $error("done flag set while pending");
  a_done_after_ack: assert property (
    ack_done |=> done_reg && !o_ctr_req.valid && irq_st_reg[SCA_IRQ_DONE_BIT])
    else $error("done flag not set after ack");
  a_dir_passed: assert property (
    start |=> o_ctr_req.dir == $past(i_hwdata[SCA_CMD_DIR_BIT]))
    else $error("direction not passed");
  a_illegal_op: assert property (
    !op_legal && ev_err |=> !o_ctr_req.valid && irq_st_reg[SCA_IRQ_ERR_BIT])
    else $error("illegal operation started");
  a_ien_readout: assert property (
    ien_capture && !wr_b1 |=> cmd_ien_reg == $past(i_ctr_rsp.ien)
    && $stable(byte1_reg)) else $error("enable bit not read out");
  a_reset_values: assert property (
    $rose(i_reset_n) |-> byte1_reg == SCA_RST_BYTE
    && select_reg == SCA_RST_SELECT && !done_reg)
    else $error("reset values wrong");

  c_value_out: cover property (start && i_hwdata[SCA_CMD_DIR_BIT] ##[1:20] capture);
  c_value_in: cover property (start && !i_hwdata[SCA_CMD_DIR_BIT] ##[1:20] ack_done);
  c_ien_out: cover property (ien_capture);
  c_irq: cover property (ev_err ##[1:20] o_irq);

endmodule
`default_nettype wire

// >>> dv/sca_testbench.sv
/*
  Self-checking bench of the counter access port: AHB-Lite master tasks,
  a counter bank answered by hand, one task per scenario.
  Assumes sca_pkg and sca_access_port are compiled before this file.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench
  import sca_pkg::*;
;
  logic            i_clk;
  logic            i_reset_n;
  logic            hsel;
  logic            hwrite;
  logic [1:0]      htrans;
  logic [31:0]     haddr;
  logic [31:0]     hwdata;
  logic [31:0]     o_hrdata;
  logic            o_hreadyout;
  logic            o_hresp;
  logic            o_irq;
  sca_ctr_req_type req;
  sca_ctr_rsp_type rsp;
  logic [31:0]     rd_s;
  logic            rdy_s;
  logic            irq_s;
  sca_ctr_req_type req_s;
  int              error_cnt;
  int              checked;

  sca_access_port DUT (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(o_hreadyout),
    .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .o_ctr_req(req), .i_ctr_rsp(rsp), .o_irq(o_irq)
  );

  // Clock of 100 MHz
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // Outputs settled mid-cycle, as seen at the next rising edge
  always @(negedge i_clk) begin
    rd_s  <= o_hrdata;
    rdy_s <= o_hreadyout;
    irq_s <= o_irq;
    req_s <= req;
  end

  // ------------------------------------------------------------
  // Report, compare and bus tasks
  // ------------------------------------------------------------
  task automatic stop_test();
    if (error_cnt == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, exp, input string m);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Wait for a handshake under a bound; a hang ends the run
  task automatic hang(input string m);
    error_cnt++;
    $display("[ERR] %0t %s timed out", $time, m);
    stop_test();
  endtask

  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (rdy_s !== 1'b1 && n < 50);
    if (rdy_s !== 1'b1) hang("bus");
  endtask

  // One single word transfer, entered and left at a rising edge
  task automatic bus(input logic w, input logic [9:0] ix,
                     input logic [7:0] d, output logic [31:0] q);
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {20'h0, ix, 2'h0};
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_rdy();
    q = rd_s;
  endtask

  task automatic wr(input logic [9:0] ix, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, ix, d, q);
  endtask

  task automatic rdc(input logic [9:0] ix, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, ix, 8'h00, q);
    chk(q, e, "register read");
  endtask

  // Counter bank: wait for a request, answer with a one-cycle ack
  task automatic ack(input logic [23:0] v, input logic e,
                     output sca_ctr_req_type r);
    int n;
    n = 0;
    while (req_s.valid !== 1'b1 && n < 50) begin
      @(posedge i_clk);
      n++;
    end
    if (req_s.valid !== 1'b1) hang("counter request");
    r = req_s;
    rsp <= '{1'b1, v, e};
    @(posedge i_clk);
    rsp.ack <= 1'b0;
  endtask

  task automatic irqc(input logic e);
    repeat (2) @(posedge i_clk);
    chk(32'(irq_s), 32'(e), "irq level");
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    logic [9:0] ix[5] = '{SCA_IDX_BYTE3, SCA_IDX_BYTE2, SCA_IDX_BYTE1,
                          SCA_IDX_SELECT, SCA_IDX_CMD};
    foreach (ix[i]) rdc(ix[i], 32'h0);
    rdc(10'h100, 32'h0);
    chk(32'(o_hresp), 32'h0, "bus response");
  endtask

  // Staged bytes read back, stay away from the counter until the command, then load it
  task automatic t_load();
    sca_ctr_req_type r;
    wr(SCA_IDX_BYTE3, 8'ha1);
    wr(SCA_IDX_BYTE2, 8'hb2);
    wr(SCA_IDX_BYTE1, 8'hc3);
    rdc(SCA_IDX_BYTE3, 32'ha1);
    rdc(SCA_IDX_BYTE2, 32'hb2);
    rdc(SCA_IDX_BYTE1, 32'hc3);
    chk(32'(req_s.valid), 32'h0, "early request");
    wr(SCA_IDX_SELECT, 8'h73);
    wr(SCA_IDX_CMD, 8'h01);
    rdc(SCA_IDX_CMD, 32'h01);
    ack(24'h0, 1'b0, r);
    chk(32'({r.op, r.dir, r.kind, r.ctr, r.unit}), 32'h09f, "load");
    chk(32'(r.wdata), 32'ha1b2c3, "load data");
    rdc(SCA_IDX_CMD, 32'h81);
    rdc(SCA_IDX_BYTE3, 32'ha1);
  endtask

  // Every category with a matching instance, read out to the bytes
  task automatic t_table();
    sca_ctr_req_type r;
    logic [3:0]      c;
    logic [1:0]      k;
    logic [23:0]     v;
    logic [5:0]      s;
    for (int i = 0; i < 12; i++) begin
      c = 4'(i);
      k = c[3] ? 2'h2 : (c[2] ? 2'h1 : 2'h0);
      v = {4'h1, c, 4'h7, ~c, 4'h3, c};
      wr(SCA_IDX_SELECT, {c, c[3], 1'b0, c[1:0]});
      wr(SCA_IDX_CMD, 8'h05);
      ack(v, 1'b0, r);
      s = {r.kind, r.ctr, r.unit};
      chk(32'(s), 32'({k, c[1:0], c[1:0]}), "sel");
      rdc(SCA_IDX_BYTE3, 32'(v[23:16]));
      rdc(SCA_IDX_BYTE2, 32'(v[15:8]));
      rdc(SCA_IDX_BYTE1, 32'(v[7:0]));
    end
  endtask

  // Enable bit moved in both directions
  task automatic t_ien();
    sca_ctr_req_type r;
    wr(SCA_IDX_CMD, 8'h0a);
    ack(24'h0, 1'b0, r);
    chk(32'({r.op, r.dir, r.ien}), 32'h9, "ien load");
    wr(SCA_IDX_CMD, 8'h06);
    ack(24'h0, 1'b1, r);
    rdc(SCA_IDX_CMD, 32'h8e);
  endtask

  // Refused commands, done event, mask and clear of the interrupt
  task automatic t_irq();
    sca_ctr_req_type r;
    logic [7:0] sel[3] = '{8'h73, 8'h73, 8'hc0};
    logic [7:0] cmd[3] = '{8'h00, 8'h03, 8'h01};
    wr(SCA_IDX_IRQ_ST, 8'h03);
    rdc(SCA_IDX_IRQ_ST, 32'h0);
    foreach (cmd[i]) begin
      wr(SCA_IDX_SELECT, sel[i]);
      wr(SCA_IDX_IRQ_MK, 8'h02);
      wr(SCA_IDX_CMD, cmd[i]);
      irqc(1'b1);
      rdc(SCA_IDX_IRQ_ST, 32'h2);
      chk(32'(req_s.valid), 32'h0, "refused");
      wr(SCA_IDX_IRQ_MK, 8'h00);
      irqc(1'b0);
      wr(SCA_IDX_IRQ_ST, 8'h02);
      rdc(SCA_IDX_IRQ_ST, 32'h0);
    end
    wr(SCA_IDX_SELECT, 8'h73);
    wr(SCA_IDX_IRQ_MK, 8'h01);
    wr(SCA_IDX_CMD, 8'h05);
    ack(24'h0, 1'b0, r);
    irqc(1'b1);
    rdc(SCA_IDX_IRQ_ST, 32'h1);
    wr(SCA_IDX_IRQ_ST, 8'h01);
    irqc(1'b0);
  endtask

  // Reset, then the scenarios in turn
  initial begin
    i_reset_n = 1'b0;
    hsel      = 1'b1;
    hwrite    = 1'b0;
    htrans    = 2'h0;
    haddr     = 32'h0;
    hwdata    = 32'h0;
    rsp       = '0;
    error_cnt = 0;
    checked   = 0;
    repeat (16) @(posedge i_clk);
    i_reset_n <= 1'b1;
    @(posedge i_clk);
    t_reset();
    t_load();
    t_table();
    t_ien();
    t_irq();
    stop_test();
  end
endmodule
`default_nettype wire
